// *** pcgd_consts.svh ***
// constants and operation summary for the clock generator and divider
// Operation
// R01: x5 mode derives core clock at five times the selected reference frequency.
// R02: crystal and external reference are combined by XOR before the multiplier.
// R03: mode pins pick static x1, x1/2, x1, or powered x5 with feedback.
// R04: multiplier acquires lock after start-up, then keeps tracking the reference.
// R05: divider passes full rate, one-sixteenth rate, or stops the clock.
// R06: clock stop ends on reset low or any interrupt pin held low.
// R07: compatibility mode halves output; phase fixed by reset falling versus phase clocks.
// R08: 8-bit lock counter forces half reference rate; frozen in reset or without reference.
// R09: slow rate lasts 256 to 257 reference cycles, then glitch-free synchronous x5 switch.
// R10: selection input chooses divider setting, applied only at a clock boundary.
`ifndef PCGD_CONSTS_SVH
`define PCGD_CONSTS_SVH

`define PCGD_LOCK_W 8
`define PCGD_LOCK_MAX 8'hFF
`define PCGD_LOCK_RST 8'h00
`define PCGD_DIV_W 4
`define PCGD_DIV_LAST 4'hF
`define PCGD_DIV_RST 4'h0
`define PCGD_MULT_N 3'h5
`define PCGD_MULT_LAST 3'h4
`define PCGD_PER_W 16
`define PCGD_REF_TIMEOUT 1024
`define PCGD_NUM_IRQ 4
`define PCGD_PIN_XIN 0
`define PCGD_PIN_EXT 1
`define PCGD_PIN_MODE_LO 2
`define PCGD_PIN_MODE_HI 3
`define PCGD_PIN_RST 4
`define PCGD_PIN_IRQ 5

`endif

// *** pcgd_pkg.sv ***
// types shared by the clock generator modules
`default_nettype none
package pcgd_pkg;
  typedef enum logic [1:0] {
    PCGD_STATIC = 2'b00,
    PCGD_HALF = 2'b01,
    PCGD_UNITY = 2'b10,
    PCGD_TIMES5 = 2'b11
  } pcgd_mode_e;
  typedef enum logic [1:0] {
    PCGD_FULL = 2'b00,
    PCGD_SIXTEENTH = 2'b01,
    PCGD_STOP = 2'b10
  } pcgd_div_e;
endpackage
`default_nettype wire

// *** pcgd_mult.sv ***
// digital x5 reference multiplier: spreads five ticks over each measured period
`timescale 1ns/1ps
`default_nettype none
`include "pcgd_consts.svh"
module pcgd_mult #(
  parameter int PER_W = `PCGD_PER_W
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic refRise,
  output logic multTick
);
  import pcgd_pkg::*;

  logic [PER_W-1:0] perCnt_ff;
  logic [PER_W-1:0] period_ff;
  logic [PER_W-1:0] stepCnt_ff;
  logic [PER_W-1:0] step;
  logic [2:0] emitted_ff;
  logic midTick;

  ////////////////////////////////////////////////////////////////////////////
  // period tracking keeps following the reference once locked
  // R04: continuous tracking
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      perCnt_ff <= '0;
      period_ff <= '0;
    end else if (refRise) begin
      perCnt_ff <= '0;
      period_ff <= perCnt_ff + 1'b1;
    end else if (perCnt_ff != {PER_W{1'b1}}) begin
      perCnt_ff <= perCnt_ff + 1'b1;
    end
  end

  // constant divide only; the remainder of up to four cycles falls into the last sub-period
  assign step = period_ff / PER_W'(`PCGD_MULT_N);
  assign midTick = (step != '0) && (stepCnt_ff == step - 1'b1) && (emitted_ff < `PCGD_MULT_LAST);
  // R01: five ticks per reference period
  assign multTick = refRise | midTick;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      stepCnt_ff <= '0;
      emitted_ff <= 3'h0;
    end else if (refRise) begin
      stepCnt_ff <= '0;
      emitted_ff <= 3'h0;
    end else if (midTick) begin
      stepCnt_ff <= '0;
      emitted_ff <= emitted_ff + 3'h1;
    end else begin
      stepCnt_ff <= stepCnt_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [2:0] perTicks_ff;
  always_ff @(posedge ref_clk) begin
    if (srst || refRise) begin
      perTicks_ff <= 3'h0;
    end else if (midTick) begin
      perTicks_ff <= perTicks_ff + 3'h1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_five_per_period: assert property ((refRise && period_ff >= PER_W'(`PCGD_MULT_N) // R01
    && period_ff == perCnt_ff + 1'b1) |-> perTicks_ff == `PCGD_MULT_LAST)
    else $error("steady reference period did not carry five ticks");
endmodule
`default_nettype wire

// *** pcgd_top.sv ***
// clock generator top: source select, x5 multiplier, lock ramp, divider, phase clocks
`timescale 1ns/1ps
`default_nettype none
`include "pcgd_consts.svh"
module pcgd_top #(
  parameter int NUM_IRQ = `PCGD_NUM_IRQ,
  parameter int REF_TIMEOUT = `PCGD_REF_TIMEOUT
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic crystal_input,
  input wire logic external_reference_input,
  input wire logic clock_mode_select_low,
  input wire logic clock_mode_select_high,
  input wire logic resetPin_n,
  input wire logic [NUM_IRQ-1:0] irqPin_n,
  input wire logic compatMode,
  input wire pcgd_pkg::pcgd_div_e divSel,
  input wire logic divSelStrobe,
  output logic crystal_drive_output,
  output logic multiplier_power_enable,
  output logic feedbackEnable,
  output logic clock_stop_state,
  output logic multLocked,
  output logic coreClkEn,
  output logic phase_one_clock_out,
  output logic phase_three_clock_out
);
  import pcgd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, second stage only is read
  logic [NUM_IRQ+4:0] pinS1_ff;
  logic [NUM_IRQ+4:0] pinS2_ff;
  // active-low pins idle high, so srst leaves no false reset or wake behind
  localparam logic [NUM_IRQ+4:0] PIN_IDLE = {{(NUM_IRQ + 1){1'b1}}, {`PCGD_PIN_RST{1'b0}}};
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pinS1_ff <= PIN_IDLE;
      pinS2_ff <= PIN_IDLE;
    end else begin
      pinS1_ff <= {irqPin_n, resetPin_n, clock_mode_select_high, clock_mode_select_low,
                   external_reference_input, crystal_input};
      pinS2_ff <= pinS1_ff;
    end
  end

  logic xinS, extS, resetS, wakeIrq;
  pcgd_mode_e mode;
  assign xinS = pinS2_ff[`PCGD_PIN_XIN];
  assign extS = pinS2_ff[`PCGD_PIN_EXT];
  assign resetS = pinS2_ff[`PCGD_PIN_RST];
  assign wakeIrq = ~&pinS2_ff[`PCGD_PIN_IRQ+NUM_IRQ-1:`PCGD_PIN_IRQ];
  // low select pin is the upper bit of the mode code
  assign mode = pcgd_mode_e'({pinS2_ff[`PCGD_PIN_MODE_LO], pinS2_ff[`PCGD_PIN_MODE_HI]});

  ////////////////////////////////////////////////////////////////////////////
  // reference combine and edge detect
  logic refLevel, refLevel_ff, refRise, resetS_ff, resetFell;
  // R02: unused source is grounded, XOR passes the live one
  assign refLevel = xinS ^ extS;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      refLevel_ff <= 1'b0;
      resetS_ff <= 1'b1;
    end else begin
      refLevel_ff <= refLevel;
      resetS_ff <= resetS;
    end
  end
  assign refRise = refLevel & ~refLevel_ff;
  assign resetFell = resetS_ff & ~resetS;

  // reference presence watchdog
  logic [$clog2(REF_TIMEOUT+1)-1:0] idleCnt_ff;
  logic refPresent;
  always_ff @(posedge ref_clk) begin
    if (srst || refRise) begin
      idleCnt_ff <= '0;
    end else if (idleCnt_ff != ($clog2(REF_TIMEOUT+1))'(REF_TIMEOUT)) begin
      idleCnt_ff <= idleCnt_ff + 1'b1;
    end
  end
  assign refPresent = idleCnt_ff != ($clog2(REF_TIMEOUT+1))'(REF_TIMEOUT);

  ////////////////////////////////////////////////////////////////////////////
  // pin-side outputs from the mode decode
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      crystal_drive_output <= 1'b0;
      multiplier_power_enable <= 1'b0;
      feedbackEnable <= 1'b0;
    end else begin
      // R03: feedback and multiplier power per mode
      feedbackEnable <= mode != PCGD_STATIC;
      multiplier_power_enable <= mode == PCGD_TIMES5;
      crystal_drive_output <= (mode != PCGD_STATIC) ? ~xinS : 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // half-rate phase and lock ramp
  logic halfPh_ff, locked_ff, multTick;
  logic [`PCGD_LOCK_W-1:0] lockCnt_ff;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      halfPh_ff <= 1'b0;
    end else if (refRise) begin
      halfPh_ff <= ~halfPh_ff;
    end
  end

  // R08: counts only with reset released and reference present
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      lockCnt_ff <= `PCGD_LOCK_RST;
    end else if (refRise && resetS && refPresent && lockCnt_ff != `PCGD_LOCK_MAX) begin
      lockCnt_ff <= lockCnt_ff + 1'b1;
    end
  end

  // R09: switch at a slow-cycle boundary so no short pulse appears
  // R04: once locked it stays locked until power-up reset
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      locked_ff <= 1'b0;
    end else if (refRise && halfPh_ff && lockCnt_ff == `PCGD_LOCK_MAX) begin
      locked_ff <= 1'b1;
    end
  end
  assign multLocked = locked_ff;

  pcgd_mult i_pcgd_mult (
    .ref_clk(ref_clk),
    .srst(srst),
    .refRise(refRise),
    .multTick(multTick)
  );

  // R03: ratio per mode
  logic srcTick;
  always_comb begin
    case (mode)
      PCGD_STATIC: srcTick = refRise;
      PCGD_HALF: srcTick = refRise & halfPh_ff;
      PCGD_UNITY: srcTick = refRise;
      // R08: half reference rate until locked
      PCGD_TIMES5: srcTick = locked_ff ? multTick : (refRise & halfPh_ff);
      default: srcTick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // divider selection, applied at the next source tick
  pcgd_div_e divMode_ff, pend_ff;
  logic pendValid_ff;
  always_ff @(posedge ref_clk) begin
    if (srst || !resetS) begin
      pendValid_ff <= 1'b0;
      pend_ff <= PCGD_FULL;
    end else if (divSelStrobe) begin
      // a fresh write beats the apply in the same cycle
      pendValid_ff <= 1'b1;
      pend_ff <= divSel;
    end else if (srcTick) begin
      pendValid_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      divMode_ff <= PCGD_FULL;
    end else if (divMode_ff == PCGD_STOP && (!resetS || wakeIrq)) begin
      // R06: wake on reset or low interrupt pin
      divMode_ff <= PCGD_FULL;
    end else if (!resetS) begin
      divMode_ff <= PCGD_FULL;
    end else if (srcTick && pendValid_ff) begin
      // R10: change only at a clock boundary
      divMode_ff <= pend_ff;
    end
  end
  assign clock_stop_state = divMode_ff == PCGD_STOP;

  logic [`PCGD_DIV_W-1:0] divCnt_ff;
  logic divTick;
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      divCnt_ff <= `PCGD_DIV_RST;
    end else if (srcTick) begin
      divCnt_ff <= divCnt_ff + 1'b1;
    end
  end

  // R05: full, one-sixteenth or stopped
  always_comb begin
    case (divMode_ff)
      PCGD_FULL: divTick = srcTick;
      PCGD_SIXTEENTH: divTick = srcTick && divCnt_ff == `PCGD_DIV_LAST;
      PCGD_STOP: divTick = 1'b0;
      default: divTick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // compatibility halving and phase clocks
  logic compatPh_ff, outTick;
  // R07: phase realigned to the phase clock state when reset falls
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      compatPh_ff <= 1'b0;
    end else if (resetFell) begin
      compatPh_ff <= phase_one_clock_out;
    end else if (divTick) begin
      compatPh_ff <= ~compatPh_ff;
    end
  end
  assign outTick = compatMode ? (divTick & compatPh_ff) : divTick;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      phase_one_clock_out <= 1'b0;
      phase_three_clock_out <= 1'b1;
      coreClkEn <= 1'b0;
    end else begin
      coreClkEn <= outTick;
      if (outTick) begin
        phase_one_clock_out <= ~phase_one_clock_out;
        phase_three_clock_out <= phase_one_clock_out;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  a_xor_source: assert property (refRise |-> (xinS ^ extS) && !$past(xinS ^ extS)) // R02
    else $error("reference edge not from xor of sources");
  a_static_pass: assert property (mode == PCGD_STATIC |-> srcTick == refRise) // R03
    else $error("static mode does not pass reference");
  a_half_ratio: assert property ((mode == PCGD_HALF && srcTick) // R03
    |=> (!srcTick || mode != PCGD_HALF) until_with refRise)
    else $error("half ratio emitted two ticks in a row");
  a_lock_held: assert property (!$fell(locked_ff)) // R04
    else $error("lock lost after acquisition");
  a_sixteenth_div: assert property ((divMode_ff == PCGD_SIXTEENTH && divTick) |-> divCnt_ff == `PCGD_DIV_LAST) // R05
    else $error("sixteenth rate tick at wrong count");
  a_stop_silent: assert property (divMode_ff == PCGD_STOP |-> !divTick) // R05
    else $error("tick while clock stopped");
  a_stop_wake: assert property ((clock_stop_state && (!resetS || wakeIrq)) |=> !clock_stop_state) // R06
    else $error("clock stop not left on wake");
  a_compat_align: assert property (resetFell |=> compatPh_ff == $past(phase_one_clock_out)) // R07
    else $error("compatibility phase not aligned at reset fall");
  a_compat_half: assert property ((compatMode && outTick) // R07
    |=> (!outTick || !compatMode) until_with divTick)
    else $error("compatibility mode did not halve");
  a_lock_frozen: assert property ((!resetS || !refPresent) |=> $stable(lockCnt_ff)) // R08
    else $error("lock counter moved in reset or without reference");
  a_switch_boundary: assert property ($rose(locked_ff) |-> $past(refRise && halfPh_ff)) // R09
    else $error("rate switch not at slow-cycle boundary");
  a_div_boundary: assert property ((resetS && $changed(divMode_ff) && $past(resetS) // R10
                                   && $past(divMode_ff) != PCGD_STOP) |-> $past(srcTick))
    else $error("divider changed away from a clock boundary");
endmodule
`default_nettype wire

// *** pcgd_top_end.sv ***
// no logic: the clock generator top is complete in its own file

// *** pcgd_ref_source.sv ***
// reference source model: crystal oscillator or external clock, one at a time
`timescale 1ns/1ps
`default_nettype none
module pcgd_ref_source #(
  parameter int HALF = 10
) (
  input wire logic ref_clk,
  input wire logic run,
  input wire logic useCrystal,
  output logic crystal_input,
  output logic external_reference_input
);
  int cnt = 0;
  logic lvl = 1'b0;
  always @(posedge ref_clk) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        lvl <= ~lvl;
      end
    end
  end
  assign crystal_input = useCrystal & lvl;
  assign external_reference_input = ~useCrystal & lvl;
endmodule
`default_nettype wire

// *** pcgd_top_bench.sv ***
// self-checking bench for the clock generator top
`timescale 1ns/1ps
`default_nettype none
module pcgd_top_bench;
  import pcgd_pkg::*;
  localparam int P = 20;
  logic ref_clk, srst, clock_mode_select_low, clock_mode_select_high, resetPin_n, compatMode, divSelStrobe;
  logic [3:0] irqPin_n;
  pcgd_div_e divSel;
  logic run, useCrystal, crystal_input, external_reference_input;
  logic crystal_drive_output, multiplier_power_enable, feedbackEnable, clock_stop_state;
  logic multLocked, coreClkEn, phase_one_clock_out, phase_three_clock_out;
  int err_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int ticks = 0;
  int waited;
  logic [31:0] rng = 32'h936D;
  ////////////////////////////////////////////////////////////////
  pcgd_ref_source #(.HALF(P / 2)) i_pcgd_ref_source (.ref_clk(ref_clk), .run(run), .useCrystal(useCrystal),
    .crystal_input(crystal_input), .external_reference_input(external_reference_input));
  pcgd_top #(.NUM_IRQ(4), .REF_TIMEOUT(64)) i_pcgd_top (.ref_clk(ref_clk), .srst(srst),
    .crystal_input(crystal_input), .external_reference_input(external_reference_input),
    .clock_mode_select_low(clock_mode_select_low), .clock_mode_select_high(clock_mode_select_high),
    .resetPin_n(resetPin_n), .irqPin_n(irqPin_n), .compatMode(compatMode), .divSel(divSel),
    .divSelStrobe(divSelStrobe), .crystal_drive_output(crystal_drive_output),
    .multiplier_power_enable(multiplier_power_enable), .feedbackEnable(feedbackEnable),
    .clock_stop_state(clock_stop_state), .multLocked(multLocked), .coreClkEn(coreClkEn),
    .phase_one_clock_out(phase_one_clock_out), .phase_three_clock_out(phase_three_clock_out));
  ////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // ticks expected over 32 reference periods
  function automatic int model(input int m, input bit locked, input pcgd_div_e d, input bit cm);
    int n;
    n = (m == 3) ? (locked ? 160 : 16) : (m == 1) ? 16 : 32;
    if (d == PCGD_SIXTEENTH) n = n / 16;
    if (d == PCGD_STOP) n = 0;
    if (cm) n = n / 2;
    return n;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // window of whole reference periods, so tick phase cannot skew the count
  task automatic measure(input string what, input int exp);
    int t0;
    repeat (4 * P) @(negedge ref_clk);
    t0 = ticks;
    repeat (32 * P) @(negedge ref_clk);
    check(what, 32'(ticks - t0), 32'(exp));
    check("phase3", 32'(phase_three_clock_out), 32'(!phase_one_clock_out));
  endtask
  task automatic set_div(input pcgd_div_e d);
    @(posedge ref_clk);
    divSel <= d;
    divSelStrobe <= 1'b1;
    @(posedge ref_clk);
    divSelStrobe <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (coreClkEn === 1'b1) begin
      ticks <= ticks + 1;
    end
    if (cycles == 40000) begin
      err_count = err_count + 1;
      end_sim();
    end
  end
  initial begin
    srst = 1'b1;
    {clock_mode_select_low, clock_mode_select_high} = 2'b11;
    resetPin_n = 1'b1;
    irqPin_n = 4'hF;
    compatMode = 1'b0;
    divSel = PCGD_FULL;
    divSelStrobe = 1'b0;
    run = 1'b1;
    useCrystal = 1'b0;
    repeat (15) @(negedge ref_clk);
    check("ph1rst", 32'(phase_one_clock_out), 32'h0);
    check("ph3rst", 32'(phase_three_clock_out), 32'h1);
    check("enrst", 32'(coreClkEn), 32'h0);
    @(posedge ref_clk);
    srst <= 1'b0;
    resetPin_n <= 1'b0;
    measure("prelock", model(3, 0, PCGD_FULL, 0));
    repeat (28 * P) @(negedge ref_clk);
    check("lockfrozen", 32'(multLocked), 32'h0);
    @(posedge ref_clk);
    resetPin_n <= 1'b1;
    run <= 1'b0;
    // reference gone with reset released: counter must stay put
    repeat (100 * P) @(negedge ref_clk);
    check("noreflock", 32'(multLocked), 32'h0);
    @(posedge ref_clk);
    run <= 1'b1;
    waited = 0;
    while (multLocked !== 1'b1 && waited < 300 * P) begin
      @(negedge ref_clk);
      waited++;
    end
    check("lockwait", 32'(waited >= 250 * P && waited <= 262 * P), 32'h1);
    for (int m = 0; m < 4; m++) begin
      rng = xs(rng);
      @(posedge ref_clk);
      useCrystal <= rng[0];
      {clock_mode_select_low, clock_mode_select_high} <= 2'(m);
      measure("modeticks", model(m, 1, PCGD_FULL, 0));
      check("feedback", 32'(feedbackEnable), 32'(m != 0));
      check("multpwr", 32'(multiplier_power_enable), 32'(m == 3));
      if (m == 0) check("xdrive", 32'(crystal_drive_output), 32'h0);
    end
    set_div(PCGD_SIXTEENTH);
    measure("sixteenth", model(3, 1, PCGD_SIXTEENTH, 0));
    set_div(PCGD_FULL);
    @(posedge ref_clk);
    compatMode <= 1'b1;
    measure("compat", model(3, 1, PCGD_FULL, 1));
    @(posedge ref_clk);
    compatMode <= 1'b0;
    for (int w = 0; w < 2; w++) begin
      set_div(PCGD_STOP);
      measure("stopped", model(3, 1, PCGD_STOP, 0));
      check("stopflag", 32'(clock_stop_state), 32'h1);
      rng = xs(rng);
      @(posedge ref_clk);
      if (w == 0) irqPin_n[rng[1:0]] <= 1'b0;
      else resetPin_n <= 1'b0;
      repeat (4) @(posedge ref_clk);
      irqPin_n <= 4'hF;
      resetPin_n <= 1'b1;
      measure("woken", model(3, 1, PCGD_FULL, 0));
      check("stopclear", 32'(clock_stop_state), 32'h0);
    end
    end_sim();
  end
endmodule
`default_nettype wire
